/* core/tsca_defs.vh */
// tsca_defs.vh: constants for the temperature sensor register bank and alert logic
// assumes: included by bare name from the design files under core/
`ifndef TSCA_DEFS_VH
`define TSCA_DEFS_VH

`define TSCA_PTR_TEMP        2'h0
`define TSCA_PTR_CFG         2'h1
`define TSCA_PTR_LOW         2'h2
`define TSCA_PTR_HIGH        2'h3

`define TSCA_CFG_STATUS      5
`define TSCA_CFG_RATE_LO     6
`define TSCA_CFG_RATE_HI     7
`define TSCA_CFG_SLEEP       8
`define TSCA_CFG_INTSEL      9
`define TSCA_CFG_POL         10
`define TSCA_CFG_FAULT_LO    11
`define TSCA_CFG_FAULT_HI    12
`define TSCA_CFG_ONE         14
`define TSCA_CFG_SHOT        15

`define TSCA_RATE_RESET      2'h2
`define TSCA_HIGH_RESET      16'h2800
`define TSCA_LOW_RESET       16'h2580
`define TSCA_THR_MASK        16'hfff0

`define TSCA_CLK_HZ          40000000
`define TSCA_CONV_MS         51
// period of each rate code in ms: 4000, 1000, 250, 125
`define TSCA_PER0_MS         4000
`define TSCA_PER1_MS         1000
`define TSCA_PER2_MS         250
`define TSCA_PER3_MS         125
`define TSCA_CNT_W           28

`endif

/* core/tsca_regmem.v */
// tsca_regmem.v: four-entry 16-bit register array with registered read data
// assumes: single clock, synchronous active-high reset, one write port
`timescale 1ns/100ps
`include "tsca_defs.vh"

module tsca_regmem (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // write port
  input  wire        wr_en,
  input  wire [1:0]  wr_addr,
  input  wire [15:0] wr_data,
  // read port
  input  wire [1:0]  rd_addr,
  output reg  [15:0] rd_data
);

  reg [15:0] mem [0:3];

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_ent
      always @(posedge clock) begin
        if (rst) begin
          mem[i] <= (i == `TSCA_PTR_LOW) ? `TSCA_LOW_RESET :
                    (i == `TSCA_PTR_HIGH) ? `TSCA_HIGH_RESET : 16'h0000;
        end else if (wr_en && (wr_addr == i)) begin
          mem[i] <= wr_data;
        end
      end
    end
  endgenerate

  always @(posedge clock) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // tsca_regmem

/* core/tsca_core.v */
// tsca_core.v: register bank, conversion scheduler and alert logic of a temperature sensor
// assumes: a serial bus engine gives byte strobes; converter hands back a result with a done pulse
//
// Function
// - pointer is eight bits; two low bits stored, upper six read zero
// - pointer 0 result, 1 configuration, 2 low, 3 high threshold
// - result read-only; configuration and both thresholds readable and writable
// - configuration is 16 bits, transferred high byte first on reads and writes
// - configuration bits 0-4 and 13 read zero, bit 14 reads one
// - status bit resets to 1; at polarity 0 it drops after high faults, returns after low faults
// - in comparator mode status bit equals alert pin, active level from polarity
// - rate field bits 7:6 give 0.25, 1, 4, 8 per second; reset 10
// - result register updates only on completed conversion
// - conversion starts at power-on; first result within 51 ms
// - idle in standby between periodic conversions until rate timer fires
// - sleep bit stops conversions at once; register access keeps working
// - sleep entry immediate; host sets single shot with sleep
// - clearing sleep resumes periodic conversion at configured rate
// - bit 9 selects comparator (0) or interrupt (1) alert mode, reset 0
// - comparator: alert active above high, until below low threshold
// - interrupt: alert goes active on each threshold crossing, held until cleared
// - bit 10 polarity: 0 active low, 1 active high, reset 0
// - fault count field needs 1 to 4 consecutive results beyond threshold
// - single shot in sleep runs one conversion, reads 1 meanwhile, then clears
// - interrupt mode alert cleared by any register read or setting sleep
// - values are signed 1/128 degree; result reads zero before first conversion
// - high threshold resets 2800, low 2580; four low bits always zero
`timescale 1ns/100ps
`include "tsca_defs.vh"

module tsca_core (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // pointer write from the bus engine
  input  wire        ptr_wr,
  input  wire [7:0]  ptr_wdata,
  output wire [7:0]  ptr_rdata,
  // register byte access, high byte first
  input  wire        byte_wr,
  input  wire        byte_rd,
  input  wire        xfer_start,
  input  wire [7:0]  byte_wdata,
  output reg  [7:0]  byte_rdata,
  // converter handshake
  output reg         conv_start,
  output wire        conv_active,
  input  wire        conv_done,
  input  wire [15:0] conv_result,
  // alert pin, driven at both levels (alert_oe_n tied low)
  output wire        alert_out,
  output wire        alert_oe_n
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_CONV  = 2'h1;
  localparam ST_SLEEP = 2'h2;

  // cycle counts are worked out as integers and cut to the timer width where they are used
  localparam integer TMO_CYC = (`TSCA_CLK_HZ / 1000) * `TSCA_CONV_MS;
  localparam integer PER0    = (`TSCA_CLK_HZ / 1000) * `TSCA_PER0_MS;
  localparam integer PER1    = (`TSCA_CLK_HZ / 1000) * `TSCA_PER1_MS;
  localparam integer PER2    = (`TSCA_CLK_HZ / 1000) * `TSCA_PER2_MS;
  localparam integer PER3    = (`TSCA_CLK_HZ / 1000) * `TSCA_PER3_MS;

  reg  [1:0]  pointer;
  reg  [1:0]  conversion_rate_field;
  reg         sleep_bit;
  reg         interrupt_select_bit;
  reg         output_polarity_bit;
  reg  [1:0]  fault_count_field;
  reg         single_shot;
  reg         threshold_fault;   // comparator state, 1 = above high
  reg         int_alert;         // interrupt-mode latched alert
  reg  [2:0]  fault_cnt;
  reg  [1:0]  state;
  reg  [`TSCA_CNT_W-1:0] timer;
  reg         second_byte;
  reg  [7:0]  wr_hi;
  reg  [15:0] temperature_result;

  wire [15:0] mem_rdata;
  reg  [15:0] low_threshold;
  reg  [15:0] high_threshold;
  reg         mem_wr;
  reg  [15:0] mem_wdata;
  wire        alert_active;
  wire        status_bit;
  wire [15:0] cfg_word;
  reg  [15:0] rd_word;
  reg  [`TSCA_CNT_W-1:0] period;
  reg         rd_stale;
  wire [1:0]  mem_raddr;

  assign ptr_rdata = {6'h00, pointer};

  // the array reads one edge late, so it follows the pointer that is being loaded
  // and a read may come straight after the pointer byte
  assign mem_raddr = ptr_wr ? ptr_wdata[1:0] : pointer;

  // thresholds also kept locally for comparison, mirrored into the array for reads
  tsca_regmem u_mem (
    .clock   (clock),
    .rst     (rst),
    .wr_en   (mem_wr),
    .wr_addr (pointer),
    .wr_data (mem_wdata),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );

  assign alert_active = interrupt_select_bit ? int_alert : threshold_fault;
  // pin level: polarity 0 drives low when active
  assign alert_out    = alert_active ~^ output_polarity_bit;
  assign alert_oe_n   = 1'b0;
  // status bit mirrors the pin in comparator mode; in interrupt mode it tracks the filter
  assign status_bit   = threshold_fault ~^ output_polarity_bit;

  assign cfg_word = {single_shot, 1'b1, 1'b0, fault_count_field, output_polarity_bit,
                     interrupt_select_bit, sleep_bit, conversion_rate_field, status_bit,
                     5'h00};

  assign conv_active = (state == ST_CONV);

  always @* begin
    case (pointer)
      `TSCA_PTR_TEMP: rd_word = temperature_result;
      `TSCA_PTR_CFG:  rd_word = cfg_word;
      default:        rd_word = rd_stale ? ((pointer == `TSCA_PTR_LOW) ? low_threshold : high_threshold) :
                                           mem_rdata;
    endcase
  end

  // right after a commit the array output is still old; the local copy is already current
  always @(posedge clock) begin
    if (rst) begin
      rd_stale <= 1'b0;
    end else begin
      rd_stale <= mem_wr;
    end
  end

  always @* begin
    case (conversion_rate_field)
      2'h0:    period = PER0[`TSCA_CNT_W-1:0];
      2'h1:    period = PER1[`TSCA_CNT_W-1:0];
      2'h2:    period = PER2[`TSCA_CNT_W-1:0];
      default: period = PER3[`TSCA_CNT_W-1:0];
    endcase
  end

  // write assembly: second byte commits the whole word
  always @* begin
    mem_wr    = byte_wr && second_byte && (pointer != `TSCA_PTR_TEMP) && (pointer != `TSCA_PTR_CFG);
    mem_wdata = {wr_hi, byte_wdata} & `TSCA_THR_MASK;
  end

  // pointer and byte order
  always @(posedge clock) begin
    if (rst) begin
      pointer     <= 2'h0;
      second_byte <= 1'b0;
      wr_hi       <= 8'h00;
      byte_rdata  <= 8'h00;
    end else begin
      if (ptr_wr) begin
        pointer <= ptr_wdata[1:0];
      end
      if (xfer_start || ptr_wr) begin
        second_byte <= 1'b0;
      end else if (byte_wr || byte_rd) begin
        second_byte <= ~second_byte;
      end
      if (byte_wr && !second_byte) begin
        wr_hi <= byte_wdata;
      end
      if (byte_rd) begin
        byte_rdata <= second_byte ? rd_word[7:0] : rd_word[15:8];
      end
    end
  end

  // configuration and threshold copies
  always @(posedge clock) begin
    if (rst) begin
      conversion_rate_field <= `TSCA_RATE_RESET;
      sleep_bit             <= 1'b0;
      interrupt_select_bit  <= 1'b0;
      output_polarity_bit   <= 1'b0;
      fault_count_field     <= 2'h0;
      low_threshold         <= `TSCA_LOW_RESET;
      high_threshold        <= `TSCA_HIGH_RESET;
    end else if (byte_wr && second_byte) begin
      if (pointer == `TSCA_PTR_CFG) begin
        conversion_rate_field <= {byte_wdata[`TSCA_CFG_RATE_HI], byte_wdata[`TSCA_CFG_RATE_LO]};
        sleep_bit             <= wr_hi[`TSCA_CFG_SLEEP-8];
        interrupt_select_bit  <= wr_hi[`TSCA_CFG_INTSEL-8];
        output_polarity_bit   <= wr_hi[`TSCA_CFG_POL-8];
        fault_count_field     <= wr_hi[`TSCA_CFG_FAULT_HI-8:`TSCA_CFG_FAULT_LO-8];
      end else if (pointer == `TSCA_PTR_LOW) begin
        low_threshold <= mem_wdata;
      end else if (pointer == `TSCA_PTR_HIGH) begin
        high_threshold <= mem_wdata;
      end
    end
  end

  wire cfg_commit = byte_wr && second_byte && (pointer == `TSCA_PTR_CFG);
  wire shot_req   = cfg_commit && wr_hi[`TSCA_CFG_SHOT-8];
  wire sleep_new  = cfg_commit && wr_hi[`TSCA_CFG_SLEEP-8];

  // conversion scheduler; reset starts a conversion right away
  always @(posedge clock) begin
    if (rst) begin
      state       <= ST_CONV;
      timer       <= {`TSCA_CNT_W{1'b0}};
      conv_start  <= 1'b1;
      single_shot <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          timer <= timer + 1'b1;
          if (sleep_new) begin
            state <= ST_SLEEP;
            if (shot_req) begin
              single_shot <= 1'b1;
              conv_start  <= 1'b1;
              state       <= ST_CONV;
            end
          end else if (timer >= period - 1'b1) begin
            timer      <= {`TSCA_CNT_W{1'b0}};
            conv_start <= 1'b1;
            state      <= ST_CONV;
          end
        end
        ST_CONV: begin
          timer <= timer + 1'b1;
          if (sleep_new && !shot_req && !single_shot) begin
            state <= ST_SLEEP;
          // a converter that never answers must not hang the scheduler past the bound
          end else if (conv_done || (timer >= TMO_CYC[`TSCA_CNT_W-1:0])) begin
            single_shot <= 1'b0;
            state <= (single_shot || sleep_bit) ? ST_SLEEP : ST_IDLE;
          end
        end
        ST_SLEEP: begin
          timer <= {`TSCA_CNT_W{1'b0}};
          if (cfg_commit && !wr_hi[`TSCA_CFG_SLEEP-8]) begin
            state <= ST_IDLE;
          end else if (shot_req) begin
            single_shot <= 1'b1;
            conv_start  <= 1'b1;
            state       <= ST_CONV;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // result capture and fault filter
  wire signed [15:0] res_s  = conv_result;
  wire signed [15:0] hi_s   = high_threshold;
  wire signed [15:0] lo_s   = low_threshold;
  wire               above  = res_s >= hi_s;
  wire               below  = res_s <= lo_s;
  wire               got    = conv_done && (state == ST_CONV);
  wire [2:0]         need   = {1'b0, fault_count_field} + 3'h1;
  wire               hit    = threshold_fault ? below : above;
  wire               fire   = got && hit && (fault_cnt + 3'h1 >= need);

  always @(posedge clock) begin
    if (rst) begin
      temperature_result <= 16'h0000;
      fault_cnt          <= 3'h0;
      threshold_fault    <= 1'b0;
      int_alert          <= 1'b0;
    end else begin
      if (got) begin
        temperature_result <= conv_result;
        if (hit) begin
          fault_cnt <= fire ? 3'h0 : fault_cnt + 3'h1;
        end else begin
          fault_cnt <= 3'h0;
        end
      end
      if (fire) begin
        threshold_fault <= ~threshold_fault;
      end
      // interrupt mode uses the same filtered crossing; a fire beats a same-cycle clear
      // the filter state decides which crossing comes next, so no separate arming flag is kept
      if (interrupt_select_bit && fire) begin
        int_alert <= 1'b1;
      end else if (byte_rd || sleep_new) begin
        int_alert <= 1'b0;
      end
      // comparator mode leaves no stale interrupt behind for a later switch back
      if (!interrupt_select_bit) begin
        int_alert <= 1'b0;
      end
    end
  end

endmodule // tsca_core

/* test/tsca_core_monitor.sv */
// tsca_core_monitor.sv: port assertions for tsca_core
// assumes: bound to tsca_core, one clock, sync active-high rst
`timescale 1ns/100ps
module tsca_core_monitor (
  // clock and reset
  input wire        clock,
  input wire        rst,
  // register side
  input wire        ptr_wr,
  input wire [7:0]  ptr_wdata,
  input wire [7:0]  ptr_rdata,
  input wire        byte_wr,
  input wire        byte_rd,
  input wire [7:0]  byte_rdata,
  // converter and alert
  input wire        conv_start,
  input wire        conv_active,
  input wire        conv_done,
  input wire        alert_out,
  input wire        alert_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_ptr_zero; ptr_rdata[7:2] == 6'h00; endproperty
  a_ptr_zero: assert property (p_ptr_zero)
    else $error("pointer upper bits set");
  property p_ptr_load; ptr_wr |=> ptr_rdata[1:0] == $past(ptr_wdata[1:0]); endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer not loaded");
  property p_ptr_hold; !ptr_wr |=> $stable(ptr_rdata); endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer changed without write");
  property p_first_conv; $fell(rst) |-> ##[0:2] conv_start; endproperty
  a_first_conv: assert property (p_first_conv)
    else $error("no conversion after reset");
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  property p_one_conv; conv_active && !conv_done |=> !conv_start; endproperty
  a_one_conv: assert property (p_one_conv)
    else $error("start during conversion");
  property p_alert_cause;
    $changed(alert_out) |-> $past(conv_done) || $past(conv_done, 2) || $past(byte_rd) || $past(byte_wr)
      || $past(byte_wr, 2);
  endproperty
  a_alert_cause: assert property (p_alert_cause)
    else $error("alert moved without cause");
  property p_rdata_hold; !byte_rd |=> $stable(byte_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read byte changed");
  property p_drive; alert_oe_n == 1'b0; endproperty
  a_drive: assert property (p_drive)
    else $error("alert pin not driven");
  c_done: cover property (conv_done);
  c_alert: cover property ($fell(alert_out));
  c_access: cover property (ptr_wr ##1 byte_rd);
endmodule // tsca_core_monitor

bind tsca_core tsca_core_monitor i_tsca_core_monitor (.clock(clock), .rst(rst), .ptr_wr(ptr_wr),
  .ptr_wdata(ptr_wdata), .ptr_rdata(ptr_rdata), .byte_wr(byte_wr), .byte_rd(byte_rd),
  .byte_rdata(byte_rdata), .conv_start(conv_start), .conv_active(conv_active), .conv_done(conv_done),
  .alert_out(alert_out), .alert_oe_n(alert_oe_n));

/* test/tsca_host.sv */
// tsca_host.sv: register-side bus host model
// assumes: one request per cycle, read byte valid after the taking edge
`timescale 1ns/100ps
module tsca_host (
  // clock
  input  wire       clock,
  // requests
  output reg        ptr_wr = 1'b0,
  output reg  [7:0] ptr_wdata = 8'h00,
  output reg        byte_wr = 1'b0,
  output reg        byte_rd = 1'b0,
  output reg        xfer_start = 1'b0,
  output reg  [7:0] byte_wdata = 8'h00,
  // read data
  input  wire [7:0] byte_rdata
);
  task set_ptr(input [7:0] p);
    begin
      @(posedge clock);
      ptr_wr <= 1'b1;
      ptr_wdata <= p;
      @(posedge clock);
      ptr_wr <= 1'b0;
      ptr_wdata <= ~p;
    end
  endtask
  // high byte leads in both directions
  task wr16(input [15:0] v);
    begin
      @(posedge clock);
      xfer_start <= 1'b1;
      @(posedge clock);
      xfer_start <= 1'b0;
      byte_wr <= 1'b1;
      byte_wdata <= v[15:8];
      @(posedge clock);
      byte_wdata <= v[7:0];
      @(posedge clock);
      byte_wr <= 1'b0;
      byte_wdata <= ~v[7:0];
      @(posedge clock);
    end
  endtask
  // pointer byte followed at once by the read, no restart in between
  task rd_fast(input [7:0] p, output [15:0] v);
    begin
      @(posedge clock);
      ptr_wr <= 1'b1;
      ptr_wdata <= p;
      @(posedge clock);
      ptr_wr <= 1'b0;
      byte_rd <= 1'b1;
      @(posedge clock);
      #1 v[15:8] = byte_rdata;
      @(posedge clock);
      byte_rd <= 1'b0;
      #1 v[7:0] = byte_rdata;
    end
  endtask
  task rd16(output [15:0] v);
    begin
      @(posedge clock);
      xfer_start <= 1'b1;
      @(posedge clock);
      xfer_start <= 1'b0;
      byte_rd <= 1'b1;
      @(posedge clock);
      #1 v[15:8] = byte_rdata;
      @(posedge clock);
      byte_rd <= 1'b0;
      #1 v[7:0] = byte_rdata;
    end
  endtask
endmodule // tsca_host

/* test/tsca_core_bench.sv */
// tsca_core_bench.sv: self-checking bench for tsca_core
// assumes: tsca_host drives the register side, converter modelled here
`timescale 1ns/100ps
module tsca_core_bench;
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg         conv_done = 1'b0;
  reg  [15:0] conv_result = 16'h0000;
  reg  [15:0] temp_val = 16'h0c80;
  reg  [7:0]  cdly = 8'h00;
  reg  [31:0] seed = 32'h1fae9542;
  reg  [15:0] d, e;
  integer     fails = 0;
  integer     samples_checked = 0;
  integer     n, k;
  wire        ptr_wr, byte_wr, byte_rd, xfer_start, conv_start, conv_active, alert_out, alert_oe_n;
  wire [7:0]  ptr_wdata, ptr_rdata, byte_wdata, byte_rdata;
  always #12.5 clock = ~clock;
  tsca_core i_tsca_core (.clock(clock), .rst(rst), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata),
    .ptr_rdata(ptr_rdata), .byte_wr(byte_wr), .byte_rd(byte_rd), .xfer_start(xfer_start),
    .byte_wdata(byte_wdata), .byte_rdata(byte_rdata), .conv_start(conv_start), .conv_active(conv_active),
    .conv_done(conv_done), .conv_result(conv_result), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
  tsca_host i_tsca_host (.clock(clock), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata), .byte_wr(byte_wr),
    .byte_rd(byte_rd), .xfer_start(xfer_start), .byte_wdata(byte_wdata), .byte_rdata(byte_rdata));
  // converter: result is only meaningful in the done cycle
  always @(posedge clock) begin
    conv_done <= (cdly == 8'h01);
    conv_result <= (cdly == 8'h01) ? temp_val : ~temp_val;
    cdly <= conv_start ? 8'h0c : (cdly != 8'h00) ? cdly - 8'h01 : 8'h00;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [15:0] cfg_exp(input [15:0] w);
    cfg_exp = (w & 16'h1fc0) | 16'h4020;
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // upper pointer bits set on purpose, they must be ignored
  task rd(input [1:0] p, output [15:0] v);
    begin
      i_tsca_host.set_ptr({6'h3f, p});
      i_tsca_host.rd16(v);
    end
  endtask
  task wr(input [1:0] p, input [15:0] v);
    begin
      i_tsca_host.set_ptr({6'h3f, p});
      i_tsca_host.wr16(v);
    end
  endtask
  // sleep and single shot go together so the first conversion is not slow
  task shot(input [15:0] base, input [15:0] t);
    integer i;
    begin
      temp_val = t;
      wr(2'h1, base | 16'h8100);
      i_tsca_host.rd16(e);
      chk(e[15], 1'b1);
      for (i = 0; i < 200 && conv_done !== 1'b1; i = i + 1) begin
        @(posedge clock);
        #1;
      end
      if (i == 200) begin
        fails = fails + 1;
        $display("[ERR] %0t conversion hung", $time);
        test_done;
      end
      repeat (3) @(posedge clock);
    end
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(2'h0, d); chk(d, 16'h0000);
    rd(2'h1, d); chk(d, 16'h40a0);
    rd(2'h2, d); chk(d, 16'h2580);
    rd(2'h3, d); chk(d, 16'h2800);
    chk({8'h00, ptr_rdata}, 16'h0003);
    wr(2'h0, 16'h1234); rd(2'h0, d); chk(d, 16'h0c80);
    for (k = 0; k < 4; k = k + 1) begin
      seed = lfsr(seed);
      d = (seed[31:16] & 16'h1ac0) | 16'h211f;
      wr(2'h1, d); rd(2'h1, e); chk(e, cfg_exp(d));
      wr(2'h3, seed[15:0]); rd(2'h3, e); chk(e, seed[15:0] & 16'hfff0);
    end
    $display("register test done");
    wr(2'h2, 16'h1000);
    i_tsca_host.rd_fast(8'h02, d);
    chk(d, 16'h1000);
    wr(2'h3, 16'h2000);
    for (n = 0; n < 4; n = n + 1) begin
      for (k = 0; k <= n; k = k + 1) begin
        shot({3'h0, n[1:0], 11'h100}, 16'h2100);
        chk(alert_out, k != n);
      end
      rd(2'h1, d); chk(d[5], alert_out);
      for (k = 0; k <= n; k = k + 1) begin
        shot({3'h0, n[1:0], 11'h100}, 16'hec00);
        chk(alert_out, k == n);
      end
    end
    $display("comparator test done");
    shot(16'h0700, 16'h2100); chk(alert_out, 1'b1);
    rd(2'h0, d); chk(d, 16'h2100);
    chk(alert_out, 1'b0);
    shot(16'h0700, 16'h0800); chk(alert_out, 1'b1);
    wr(2'h1, 16'h0700); chk(alert_out, 1'b0);
    $display("interrupt test done");
    test_done;
  end
endmodule // tsca_core_bench
